// >>> hdl/lmr_exec_consts.svh
`ifndef LMR_EXEC_CONSTS_SVH
`define LMR_EXEC_CONSTS_SVH

// Register byte offsets on the slave port
`define REG_INSTR   8'h00
`define REG_ACC     8'h04
`define REG_FLAGS   8'h08
`define REG_PC      8'h0C
`define REG_TOP     8'h10
`define REG_FADDR   8'h14
`define REG_FDATA   8'h18

// Widths of the instruction word and the flag word
`define INSTR_W     24
`define FLAGS_W     3

// Reset values
`define ACC_RST     8'h00
`define FLAGS_RST   3'h0
`define FADDR_RST   7'h00
`define RDATA_RST   32'h0000_0000

`endif

// >>> hdl/exec_pkg.sv
`default_nettype none

package exec_pkg;

  typedef enum logic [3:0] {
    OP_IDLE     = 4'h0,
    OP_OR_LIT   = 4'h1,
    OP_LOAD_LIT = 4'h2,
    OP_OR_FILE  = 4'h3,
    OP_STORE    = 4'h4,
    OP_COPY     = 4'h5,
    OP_RETI     = 4'h6,
    OP_ROTL     = 4'h7
  } op_t;

  // Instruction word, bit 23 down to bit 0
  typedef struct packed {
    logic       tsel;
    logic [6:0] addr;
    logic [7:0] imm;
    logic [3:0] spare;
    op_t        op;
  } instr_t;

  // Flag word, bit 2 down to bit 0
  typedef struct packed {
    logic global_irq_enable;
    logic rot;
    logic zero;
  } flags_t;

  typedef struct packed {
    logic [7:0] res;
    logic       wr_acc;
    logic       wr_file;
    logic       wr_zero;
    logic       zero;
    logic       wr_rot;
    logic       rot;
    logic       set_gie;
    logic       pop;
    logic       adv_pc;
  } alu_out_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_ACK  = 2'b10
  } bus_state_t;

endpackage

`default_nettype wire

// >>> hdl/exec_alu.sv
`default_nettype none

module exec_alu (
  input  wire exec_pkg::instr_t   i_instr,
  input  wire logic [7:0]         i_acc,
  input  wire logic [7:0]         i_fdata,
  input  wire exec_pkg::flags_t   i_flags,
  output var  exec_pkg::alu_out_t o_out
);

  always_comb
  begin
    o_out        = '0;
    o_out.adv_pc = 1'b1;
    case (i_instr.op)
      exec_pkg::OP_OR_LIT:
      begin
        o_out.res     = i_acc | i_instr.imm;
        o_out.wr_acc  = 1'b1;
        o_out.wr_zero = 1'b1;
      end
      exec_pkg::OP_LOAD_LIT:
      begin
        // Only op and immediate are looked at
        o_out.res    = i_instr.imm;
        o_out.wr_acc = 1'b1;
      end
      exec_pkg::OP_OR_FILE:
      begin
        o_out.res     = i_acc | i_fdata;
        o_out.wr_acc  = ~i_instr.tsel;
        o_out.wr_file = i_instr.tsel;
        o_out.wr_zero = 1'b1;
      end
      exec_pkg::OP_STORE:
      begin
        o_out.res     = i_acc;
        o_out.wr_file = 1'b1;
      end
      exec_pkg::OP_COPY:
      begin
        // Self copy rewrites the same value: a zero test
        o_out.res     = i_fdata;
        o_out.wr_acc  = ~i_instr.tsel;
        o_out.wr_file = i_instr.tsel;
        o_out.wr_zero = 1'b1;
      end
      exec_pkg::OP_RETI:
      begin
        o_out.set_gie = 1'b1;
        o_out.pop     = 1'b1;
        o_out.adv_pc  = 1'b0;
      end
      exec_pkg::OP_ROTL:
      begin
        o_out.res     = {i_fdata[6:0], i_flags.rot};
        o_out.rot     = i_fdata[7];
        o_out.wr_rot  = 1'b1;
        o_out.wr_acc  = ~i_instr.tsel;
        o_out.wr_file = i_instr.tsel;
      end
      default:
      begin
        // Idle and unknown codes only advance the counter
        o_out.adv_pc = 1'b1;
      end
    endcase
    o_out.zero = (o_out.res == 8'h00);
  end

endmodule // exec_alu

`default_nettype wire

// >>> hdl/literal_move_or_rotate_exec.sv
// The address map and register access over Avalon-MM were left to the implementer.
`include "lmr_exec_consts.svh"
`default_nettype none

module literal_move_or_rotate_exec #(
  parameter int PC_W        = 13,
  parameter int STACK_DEPTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_clk_en,
  input  wire logic [7:0]       i_avs_address,
  input  wire logic             i_avs_read,
  input  wire logic             i_avs_write,
  input  wire logic [31:0]      i_avs_writedata,
  input  wire logic [3:0]       i_avs_byteenable,
  output logic      [31:0]      o_avs_readdata,
  output logic                  o_avs_waitrequest,
  output logic      [7:0]       o_acc,
  output logic      [PC_W-1:0]  o_pc,
  output logic                  o_gie
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge, used by every register write except REG_FDATA

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  exec_pkg::bus_state_t state_r, state_nxt;
  logic [7:0]           acc_r, acc_nxt;
  exec_pkg::flags_t     flags_r, flags_nxt;
  logic [PC_W-1:0]      pc_r, pc_nxt;
  logic [SP_W-1:0]      sp_r, sp_nxt;
  logic [6:0]           faddr_r, faddr_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic [7:0]           file_mem [128];
  logic [PC_W-1:0]      stack_mem [STACK_DEPTH];

  logic                 file_we;
  logic [6:0]           file_wa;
  logic [7:0]           file_wd;
  logic                 push_we;
  logic [PC_W-1:0]      push_wd;

  logic                 req;
  logic                 take;
  logic                 wr_hit;
  logic                 exec_fire;
  logic [31:0]          instr_word;
  exec_pkg::instr_t     instr;
  exec_pkg::alu_out_t   alu;
  logic [PC_W-1:0]      stack_top;

  assign req       = i_avs_read | i_avs_write;
  // Effects land on the one edge the master sees waitrequest low
  assign take      = (state_r == exec_pkg::S_ACK) & i_clk_en;
  assign wr_hit    = take & i_avs_write;
  assign exec_fire = wr_hit & (i_avs_address == `REG_INSTR);
  // Disabled lanes read as zero, so unused fields decode as zeros
  assign instr_word = merge_be(32'h0000_0000, i_avs_writedata,
                               i_avs_byteenable);
  assign instr     = exec_pkg::instr_t'(instr_word[`INSTR_W-1:0]);
  assign stack_top = stack_mem[sp_r - SP_W'(1)];

  exec_alu u_alu (
    .i_instr (instr),
    .i_acc   (acc_r),
    .i_fdata (file_mem[instr.addr]),
    .i_flags (flags_r),
    .o_out   (alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    state_nxt = state_r;
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    pc_nxt    = pc_r;
    sp_nxt    = sp_r;
    faddr_nxt = faddr_r;
    rdata_nxt = rdata_r;
    file_we   = 1'b0;
    file_wa   = instr.addr;
    file_wd   = alu.res;
    push_we   = 1'b0;
    push_wd   = '0;

    case (state_r)
      exec_pkg::S_IDLE:
      begin
        if (req)
        begin
          state_nxt = exec_pkg::S_ACK;
          case (i_avs_address)
            `REG_ACC:   rdata_nxt = {24'h00_0000, acc_r};
            `REG_FLAGS: rdata_nxt = {29'h0000_0000, flags_r};
            `REG_PC:    rdata_nxt = 32'(pc_r);
            `REG_TOP:   rdata_nxt = 32'(stack_top);
            `REG_FADDR: rdata_nxt = {25'h000_0000, faddr_r};
            `REG_FDATA: rdata_nxt = {24'h00_0000, file_mem[faddr_r]};
            default:    rdata_nxt = `RDATA_RST;
          endcase
        end
      end
      exec_pkg::S_ACK:
      begin
        state_nxt = exec_pkg::S_IDLE;
      end
      default:
      begin
        state_nxt = exec_pkg::S_IDLE;
      end
    endcase

    if (exec_fire)
    begin
      if (alu.wr_acc)
        acc_nxt = alu.res;
      if (alu.wr_zero)
        flags_nxt.zero = alu.zero;
      if (alu.wr_rot)
        flags_nxt.rot = alu.rot;
      if (alu.set_gie)
        flags_nxt.global_irq_enable = 1'b1;
      file_we = alu.wr_file;
      if (alu.pop)
      begin
        pc_nxt = stack_top;
        sp_nxt = sp_r - SP_W'(1);
      end
      else if (alu.adv_pc)
        pc_nxt = pc_r + PC_W'(1);
    end
    else if (wr_hit)
    begin
      case (i_avs_address)
        `REG_ACC:
          acc_nxt = 8'(merge_be({24'h00_0000, acc_r}, i_avs_writedata,
                                i_avs_byteenable));
        `REG_FLAGS:
          flags_nxt = exec_pkg::flags_t'(3'(merge_be({29'h0, flags_r},
                        i_avs_writedata, i_avs_byteenable)));
        `REG_PC:
          pc_nxt = PC_W'(merge_be(32'(pc_r), i_avs_writedata,
                                  i_avs_byteenable));
        `REG_TOP:
        begin
          // Software push stands in for a call; a full stack wraps
          push_we = 1'b1;
          push_wd = PC_W'(merge_be(32'h0000_0000, i_avs_writedata,
                                   i_avs_byteenable));
          sp_nxt  = sp_r + SP_W'(1);
        end
        `REG_FADDR:
          faddr_nxt = 7'(merge_be({25'h000_0000, faddr_r}, i_avs_writedata,
                                  i_avs_byteenable));
        `REG_FDATA:
        begin
          file_we = i_avs_byteenable[0];
          file_wa = faddr_r;
          file_wd = i_avs_writedata[7:0];
        end
        default:
        begin
          file_we = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      state_r <= exec_pkg::S_IDLE;
      acc_r   <= `ACC_RST;
      flags_r <= `FLAGS_RST;
      pc_r    <= '0;
      sp_r    <= '0;
      faddr_r <= `FADDR_RST;
      rdata_r <= `RDATA_RST;
    end
    else if (i_clk_en)
    begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
      pc_r    <= pc_nxt;
      sp_r    <= sp_nxt;
      faddr_r <= faddr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Arrays have no reset; contents are undefined until written
  always_ff @(posedge i_core_clk)
  begin
    if (i_clk_en && file_we)
      file_mem[file_wa] <= file_wd;
    if (i_clk_en && push_we)
      stack_mem[sp_r] <= push_wd;
  end

  // Held high while frozen, so the master never sees an ack edge that is lost
  assign o_avs_waitrequest = ~take;
  assign o_avs_readdata    = rdata_r;
  assign o_acc             = acc_r;
  assign o_pc              = pc_r;
  assign o_gie             = flags_r.global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence seq_fire(exec_pkg::op_t op);
    exec_fire && (instr.op == op);
  endsequence

  a_or_lit_acc: assert property (seq_fire(exec_pkg::OP_OR_LIT) |=>
    acc_r == ($past(acc_r) | $past(instr.imm)) &&
    flags_r.zero == (($past(acc_r) | $past(instr.imm)) == 8'h00))
    else $error("or literal result or zero flag wrong");

  a_load_lit_flags: assert property (seq_fire(exec_pkg::OP_LOAD_LIT)
    |=> acc_r == $past(instr.imm) && flags_r == $past(flags_r))
    else $error("load literal wrong value or flags moved");

  a_load_dontcare: assert property (seq_fire(exec_pkg::OP_LOAD_LIT)
    |=> pc_r == $past(pc_r) + PC_W'(1) && sp_r == $past(sp_r))
    else $error("load literal touched stack or pc wrongly");

  a_or_file_dest: assert property (seq_fire(exec_pkg::OP_OR_FILE)
    ##0 !instr.tsel |=>
    acc_r == ($past(acc_r) | $past(file_mem[instr.addr])))
    else $error("or file to accumulator wrong");

  a_store_flags: assert property (seq_fire(exec_pkg::OP_STORE) |=>
    flags_r == $past(flags_r) && acc_r == $past(acc_r))
    else $error("store changed flags or accumulator");

  a_copy_zero: assert property (seq_fire(exec_pkg::OP_COPY) |=>
    flags_r.zero == ($past(file_mem[instr.addr]) == 8'h00))
    else $error("copy zero flag wrong");

  a_copy_self: assert property (seq_fire(exec_pkg::OP_COPY) ##0
    instr.tsel |=> acc_r == $past(acc_r) &&
    file_mem[$past(instr.addr)] == $past(file_mem[instr.addr]))
    else $error("self copy changed accumulator");

  a_reti_gie: assert property (seq_fire(exec_pkg::OP_RETI) |=>
    flags_r.global_irq_enable && pc_r == $past(stack_top) &&
    sp_r == $past(sp_r) - SP_W'(1))
    else $error("return did not pop or enable interrupts");

  a_rotl_carry: assert property (seq_fire(exec_pkg::OP_ROTL) ##0
    !instr.tsel |=> acc_r == {$past(file_mem[instr.addr][6:0]),
    $past(flags_r.rot)} && flags_r.rot == $past(file_mem[instr.addr][7]))
    else $error("rotate left result or carry wrong");

  a_rotl_only_c: assert property (seq_fire(exec_pkg::OP_ROTL) |=>
    flags_r.zero == $past(flags_r.zero) && flags_r.global_irq_enable == $past(flags_r.global_irq_enable))
    else $error("rotate touched other flags");

  a_idle_pc: assert property (seq_fire(exec_pkg::OP_IDLE) |=>
    pc_r == $past(pc_r) + PC_W'(1) && acc_r == $past(acc_r) &&
    flags_r == $past(flags_r))
    else $error("idle changed state beyond pc");

  a_wait_answer: assert property ((state_r == exec_pkg::S_IDLE) && req &&
    i_clk_en |=> state_r == exec_pkg::S_ACK &&
    o_avs_waitrequest == !i_clk_en)
    else $error("answer not given one cycle after request");

endmodule // literal_move_or_rotate_exec

`default_nettype wire

// >>> verification/test_literal_move_or_rotate_exec.sv
`include "lmr_exec_consts.svh"
`default_nettype none

module test_literal_move_or_rotate_exec;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_core_clk;
  logic        i_rst_b;
  logic        i_clk_en;
  logic [7:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [7:0]  o_acc;
  logic [12:0] o_pc;
  logic        o_gie;
  int          n_fail;
  int          compares;
  logic [31:0] q;
  logic [12:0] pc_e;

  always #25 i_core_clk = ~i_core_clk;

  literal_move_or_rotate_exec dut (
    .i_core_clk        (i_core_clk),
    .i_rst_b           (i_rst_b),
    .i_clk_en          (i_clk_en),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_acc             (o_acc),
    .o_pc              (o_pc),
    .o_gie             (o_gie)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stands until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    i_avs_writedata <= d;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (o_avs_waitrequest !== 1'b0 && n < 40);
    // Read data taken at the ack edge itself
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    if (o_avs_waitrequest !== 1'b0)
    begin
      n_fail++;
      $display("[FAIL] %0t bus answer timeout", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic ex(input exec_pkg::op_t op, input logic t,
                    input logic [6:0] f, input logic [7:0] k,
                    input logic [3:0] sp);
    wr(`REG_INSTR, {8'h00, t, f, k, sp, op});
    // Results land at the ack edge; let them settle before compares
    @(posedge i_core_clk);
    pc_e++;
  endtask

  task automatic fset(input logic [6:0] f, input logic [7:0] v);
    wr(`REG_FADDR, {25'h0, f});
    wr(`REG_FDATA, {24'h0, v});
  endtask

  task automatic fchk(input logic [6:0] f, input logic [7:0] e);
    wr(`REG_FADDR, {25'h0, f});
    rd_chk(`REG_FDATA, {24'h0, e});
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_core_clk       = 1'b0;
    i_rst_b          = 1'b0;
    i_clk_en         = 1'b1;
    i_avs_address    = 8'h00;
    i_avs_read       = 1'b0;
    i_avs_write      = 1'b0;
    i_avs_writedata  = 32'h0000_0000;
    i_avs_byteenable = 4'hF;
    n_fail           = 0;
    compares         = 0;
    pc_e             = 13'h0000;
    repeat (20) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    // Reset state and refused accesses
    rd_chk(`REG_ACC, 32'h0000_0000);
    rd_chk(`REG_FLAGS, 32'h0000_0000);
    rd_chk(`REG_PC, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000);
    rd_chk(`REG_INSTR, 32'h0000_0000);
    // Load with junk in the spare and operand fields
    wr(`REG_FLAGS, 32'h0000_0003);
    ex(exec_pkg::OP_LOAD_LIT, 1'b1, 7'h7F, 8'hA5, 4'hF);
    chk({24'h0, o_acc}, 32'h0000_00A5);
    rd_chk(`REG_FLAGS, 32'h0000_0003);
    // OR immediate: zero result, then non-zero
    wr(`REG_ACC, 32'h0000_0000);
    wr(`REG_FLAGS, 32'h0000_0000);
    ex(exec_pkg::OP_OR_LIT, 1'b0, 7'h00, 8'h00, 4'h0);
    rd_chk(`REG_FLAGS, 32'h0000_0001);
    ex(exec_pkg::OP_OR_LIT, 1'b0, 7'h00, 8'h80, 4'h0);
    ex(exec_pkg::OP_OR_LIT, 1'b0, 7'h00, 8'h01, 4'h0);
    chk({24'h0, o_acc}, 32'h0000_0081);
    rd_chk(`REG_FLAGS, 32'h0000_0000);
    // Store to the highest file address
    wr(`REG_FLAGS, 32'h0000_0001);
    ex(exec_pkg::OP_STORE, 1'b0, 7'h7F, 8'h00, 4'h0);
    fchk(7'h7F, 8'h81);
    rd_chk(`REG_FLAGS, 32'h0000_0001);
    // OR with file, both destinations
    fset(7'h10, 8'h0C);
    wr(`REG_ACC, 32'h0000_0030);
    ex(exec_pkg::OP_OR_FILE, 1'b0, 7'h10, 8'h00, 4'h0);
    chk({24'h0, o_acc}, 32'h0000_003C);
    rd_chk(`REG_FLAGS, 32'h0000_0000);
    fchk(7'h10, 8'h0C);
    wr(`REG_ACC, 32'h0000_0041);
    ex(exec_pkg::OP_OR_FILE, 1'b1, 7'h10, 8'h00, 4'h0);
    fchk(7'h10, 8'h4D);
    chk({24'h0, o_acc}, 32'h0000_0041);
    // Copy to itself tests for zero; copy to accumulator
    fset(7'h20, 8'h00);
    wr(`REG_ACC, 32'h0000_0055);
    ex(exec_pkg::OP_COPY, 1'b1, 7'h20, 8'h00, 4'h0);
    rd_chk(`REG_FLAGS, 32'h0000_0001);
    fchk(7'h20, 8'h00);
    chk({24'h0, o_acc}, 32'h0000_0055);
    fset(7'h21, 8'h9A);
    ex(exec_pkg::OP_COPY, 1'b0, 7'h21, 8'h00, 4'h0);
    chk({24'h0, o_acc}, 32'h0000_009A);
    rd_chk(`REG_FLAGS, 32'h0000_0000);
    // Rotate: carry in and out, zero flag must not move
    wr(`REG_FLAGS, 32'h0000_0002);
    fset(7'h30, 8'h81);
    ex(exec_pkg::OP_ROTL, 1'b0, 7'h30, 8'h00, 4'h0);
    chk({24'h0, o_acc}, 32'h0000_0003);
    fchk(7'h30, 8'h81);
    wr(`REG_FLAGS, 32'h0000_0001);
    ex(exec_pkg::OP_ROTL, 1'b1, 7'h30, 8'h00, 4'h0);
    fchk(7'h30, 8'h02);
    rd_chk(`REG_FLAGS, 32'h0000_0003);
    chk({24'h0, o_acc}, 32'h0000_0003);
    // Return twice after two pushes onto the stack
    wr(`REG_TOP, 32'h0000_0123);
    wr(`REG_TOP, 32'h0000_0456);
    rd_chk(`REG_TOP, 32'h0000_0456);
    ex(exec_pkg::OP_RETI, 1'b0, 7'h00, 8'h00, 4'h0);
    chk({19'h0, o_pc}, 32'h0000_0456);
    chk({31'h0, o_gie}, 32'h0000_0001);
    rd_chk(`REG_FLAGS, 32'h0000_0007);
    ex(exec_pkg::OP_RETI, 1'b0, 7'h00, 8'h00, 4'h0);
    chk({19'h0, o_pc}, 32'h0000_0123);
    pc_e = 13'h0123;
    // Idle under a clock-enable stall, and an unused opcode
    i_clk_en <= 1'b0;
    fork
      ex(exec_pkg::OP_IDLE, 1'b1, 7'h30, 8'hFF, 4'h0);
      begin
        repeat (4) @(posedge i_core_clk);
        i_clk_en <= 1'b1;
      end
    join
    ex(exec_pkg::op_t'(4'hF), 1'b1, 7'h30, 8'hFF, 4'h0);
    chk({19'h0, o_pc}, {19'h0, pc_e});
    chk({24'h0, o_acc}, 32'h0000_0003);
    rd_chk(`REG_FLAGS, 32'h0000_0007);
    fchk(7'h30, 8'h02);
    // Disabled byte lane leaves the file register alone
    i_avs_byteenable <= 4'h0;
    wr(`REG_FDATA, 32'h0000_0077);
    i_avs_byteenable <= 4'hF;
    fchk(7'h30, 8'h02);
    finish_test();
  end

endmodule // test_literal_move_or_rotate_exec

`default_nettype wire
